// [pwr_seq_pkg.sv]
// Package with states, timing constants and carried signal groups for the power sequencer.
package pwr_seq_pkg;

  // System power states.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_GOOD,
    ST_ON,
    ST_WARN,
    ST_S3,
    ST_S5
  } pwr_state_e;

  // Sleep depth requested by the host side.
  localparam logic [1:0] SLEEP_S3 = 2'h1;
  localparam logic [1:0] SLEEP_S4 = 2'h2;
  localparam logic [1:0] SLEEP_S5 = 2'h3;

  // Advance notice before a low power state, in microseconds.
  localparam int WARN_TIME_US   = 10;
  localparam int CLK_MHZ        = 25;
  localparam int WARN_CYCLES    = WARN_TIME_US * CLK_MHZ;
  localparam int WARN_CNT_W     = 9;
  localparam logic [WARN_CNT_W-1:0] WARN_LAST = WARN_CNT_W'(WARN_CYCLES - 1);
  localparam logic [WARN_CNT_W-1:0] WARN_ZERO = 9'h000;

  // Synchroniser depth.
  localparam int SYNC_STAGES = 2;

  // Conditioned carrier inputs, all active high after synchronising.
  typedef struct packed {
    logic power_good;
    logic power_press;
    logic reset_req;
    logic battery_low;
    logic wake_req;
    logic sleep_press;
    logic lid_event;
  } carrier_events_s;

endpackage

// [pwr_sync.sv]
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/1ps
module pwr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Level in and out.
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// [pwr_edge.sv]
// Falling- and rising-edge detector on a synchronised active-low level.
`timescale 1ns/1ps
module pwr_edge (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Synchronised level and detected edge.
  input  wire logic i_level,
  output logic      o_fall,
  output logic      o_rise
);

  logic prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= i_level;
    end
  end

  assign o_fall = prev_q & ~i_level;
  assign o_rise = ~prev_q & i_level;

endmodule

// [pwr_state_ctrl.sv]
`timescale 1ns/1ps
module pwr_state_ctrl (
  // Clock and reset.
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  // Carrier inputs.
  input  wire logic       I_CARRIER_POWER_GOOD,
  input  wire logic       I_POWER_BUTTON_N,
  input  wire logic       I_RESET_BUTTON_N,
  input  wire logic       I_BATTERY_LOW_N,
  input  wire logic       I_WAKE_N,
  input  wire logic       I_SLEEP_BUTTON_N,
  input  wire logic       I_LID_SWITCH_N,
  // Host-side control.
  input  wire logic       I_LID_CLOSED_HIGH,
  input  wire logic [1:0] I_SLEEP_DEPTH,
  // Carrier outputs.
  output logic            O_SUSPEND_WARNING_N,
  output logic            O_SLEEP_RAM_OFF_N,
  output logic            O_SOFT_OFF_N,
  // Status to the host side.
  output logic            O_MODULE_RESET,
  output logic            O_BATTERY_LOW,
  output logic            O_WAKE_EVENT,
  output logic            O_POWER_PRESS,
  output logic            O_SLEEP_PRESS,
  output logic            O_LID_CLOSED,
  output logic [2:0]      O_STATE
);

  pwr_seq_pkg::carrier_events_s ev;
  pwr_seq_pkg::pwr_state_e      state_q;
  pwr_seq_pkg::pwr_state_e      state_d;
  logic [pwr_seq_pkg::WARN_CNT_W-1:0] warn_cnt_q;
  logic [1:0] target_q;
  logic       pg_s;
  logic       pbtn_s;
  logic       rbtn_s;
  logic       batt_s;
  logic       wake_s;
  logic       sbtn_s;
  logic       lid_s;
  logic       lid_fall;
  logic       lid_rise;
  logic       lid_closed;
  logic       sys_reset;
  logic       warn_done;

  pwr_sync #(.RESET_VAL(1'b0)) u_sync_pg (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_CARRIER_POWER_GOOD), .o_sync(pg_s));
  pwr_sync u_sync_pb (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_POWER_BUTTON_N), .o_sync(pbtn_s));
  pwr_sync u_sync_rb (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_RESET_BUTTON_N), .o_sync(rbtn_s));
  pwr_sync u_sync_bl (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_BATTERY_LOW_N), .o_sync(batt_s));
  pwr_sync u_sync_wk (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_WAKE_N), .o_sync(wake_s));
  pwr_sync u_sync_sb (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_SLEEP_BUTTON_N), .o_sync(sbtn_s));
  pwr_sync u_sync_ld (.i_clk(I_CLK), .i_reset(I_RESET),
    .i_async(I_LID_SWITCH_N), .o_sync(lid_s));

  logic pb_fall;
  logic sb_fall;

  pwr_edge u_edge_pb (.i_clk(I_CLK), .i_reset(I_RESET), .i_level(pbtn_s),
    .o_fall(pb_fall), .o_rise());
  pwr_edge u_edge_sb (.i_clk(I_CLK), .i_reset(I_RESET), .i_level(sbtn_s),
    .o_fall(sb_fall), .o_rise());
  pwr_edge u_edge_ld (.i_clk(I_CLK), .i_reset(I_RESET), .i_level(lid_s),
    .o_fall(lid_fall), .o_rise(lid_rise));

  // The lid input is low for closed by default; the control bit swaps the sense.
  assign lid_closed = I_LID_CLOSED_HIGH ? lid_s : ~lid_s;

  always_comb begin
    ev.power_good  = pg_s;
    ev.power_press = pb_fall;
    ev.reset_req   = ~rbtn_s;
    ev.battery_low = ~batt_s;
    ev.wake_req    = ~wake_s;
    ev.sleep_press = sb_fall;
    // Either lid edge is an event; the new level tells closing from opening.
    ev.lid_event   = lid_rise | lid_fall;
  end

  assign sys_reset = I_RESET | ev.reset_req;
  assign warn_done = (warn_cnt_q == pwr_seq_pkg::WARN_LAST);

  // Sleep depth, or S5 for a power press, is latched when the warning phase starts.
  always_ff @(posedge I_CLK) begin
    if (sys_reset) begin
      target_q <= pwr_seq_pkg::SLEEP_S5;
    end else if (state_q == pwr_seq_pkg::ST_ON && state_d == pwr_seq_pkg::ST_WARN) begin
      target_q <= (!ev.power_press && (ev.sleep_press || ev.lid_event)) ? I_SLEEP_DEPTH
                                                                         : pwr_seq_pkg::SLEEP_S5;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      pwr_seq_pkg::ST_OFF: begin
        if (ev.power_press || ev.wake_req) begin
          state_d = pwr_seq_pkg::ST_WAIT_GOOD;
        end
      end
      pwr_seq_pkg::ST_WAIT_GOOD: begin
        if (ev.power_good) begin
          state_d = pwr_seq_pkg::ST_ON;
        end
      end
      pwr_seq_pkg::ST_ON: begin
        if (!ev.power_good) begin
          state_d = pwr_seq_pkg::ST_WAIT_GOOD;
        end else if (ev.power_press || ev.sleep_press || (ev.lid_event && lid_closed)) begin
          state_d = pwr_seq_pkg::ST_WARN;
        end
      end
      pwr_seq_pkg::ST_WARN: begin
        if (warn_done) begin
          state_d = (target_q == pwr_seq_pkg::SLEEP_S3) ? pwr_seq_pkg::ST_S3
                                                        : pwr_seq_pkg::ST_S5;
        end
      end
      pwr_seq_pkg::ST_S3: begin
        if (ev.power_press || ev.sleep_press || ev.wake_req || (ev.lid_event && !lid_closed)) begin
          state_d = pwr_seq_pkg::ST_WAIT_GOOD;
        end
      end
      pwr_seq_pkg::ST_S5: begin
        if (ev.power_press || ev.wake_req) begin
          state_d = pwr_seq_pkg::ST_WAIT_GOOD;
        end
      end
      default: begin
        state_d = pwr_seq_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (sys_reset) begin
      state_q <= pwr_seq_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Warning phase length counter.
  always_ff @(posedge I_CLK) begin
    if (sys_reset || state_q != pwr_seq_pkg::ST_WARN) begin
      warn_cnt_q <= pwr_seq_pkg::WARN_ZERO;
    end else if (!warn_done) begin
      warn_cnt_q <= warn_cnt_q + 1'b1;
    end
  end

  // Rail outputs are registered from the next state so they track the state register.
  always_ff @(posedge I_CLK) begin
    if (sys_reset) begin
      O_SUSPEND_WARNING_N <= 1'b0;
      O_SLEEP_RAM_OFF_N   <= 1'b0;
      O_SOFT_OFF_N        <= 1'b0;
    end else begin
      O_SUSPEND_WARNING_N <= !(state_d == pwr_seq_pkg::ST_WARN ||
                               state_d == pwr_seq_pkg::ST_S3 ||
                               state_d == pwr_seq_pkg::ST_S5 ||
                               state_d == pwr_seq_pkg::ST_OFF);
      O_SLEEP_RAM_OFF_N   <= !(state_d == pwr_seq_pkg::ST_S3 ||
                               state_d == pwr_seq_pkg::ST_S5 ||
                               state_d == pwr_seq_pkg::ST_OFF);
      O_SOFT_OFF_N        <= !(state_d == pwr_seq_pkg::ST_S5 ||
                               state_d == pwr_seq_pkg::ST_OFF);
    end
  end

  // Status outputs to the host side.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_MODULE_RESET <= 1'b1;
      O_BATTERY_LOW  <= 1'b0;
      O_WAKE_EVENT   <= 1'b0;
      O_POWER_PRESS  <= 1'b0;
      O_SLEEP_PRESS  <= 1'b0;
      O_LID_CLOSED   <= 1'b0;
    end else begin
      O_MODULE_RESET <= ev.reset_req;
      O_BATTERY_LOW  <= ev.battery_low;
      O_WAKE_EVENT   <= ev.wake_req;
      O_POWER_PRESS  <= ev.power_press;
      O_SLEEP_PRESS  <= ev.sleep_press;
      O_LID_CLOSED   <= lid_closed;
    end
  end

  // The state code tracks the state register, so a reset-button reset shows as off at once.
  always_ff @(posedge I_CLK) begin
    if (sys_reset) begin
      O_STATE <= 3'(pwr_seq_pkg::ST_OFF);
    end else begin
      O_STATE <= 3'(state_d);
    end
  end

endmodule

// [pwr_state_ctrl_sva.sv]
// Port assertions for the power sequencer.
`timescale 1ns/1ps
module pwr_state_ctrl_sva (
  // Clock, reset and carrier inputs.
  input wire logic       I_CLK,
  input wire logic       I_RESET,
  input wire logic       I_CARRIER_POWER_GOOD,
  input wire logic       I_POWER_BUTTON_N,
  input wire logic       I_RESET_BUTTON_N,
  input wire logic       I_BATTERY_LOW_N,
  input wire logic       I_SLEEP_BUTTON_N,
  // Outputs under watch.
  input wire logic       O_SUSPEND_WARNING_N,
  input wire logic       O_SLEEP_RAM_OFF_N,
  input wire logic       O_SOFT_OFF_N,
  input wire logic       O_MODULE_RESET,
  input wire logic       O_BATTERY_LOW,
  input wire logic       O_POWER_PRESS,
  input wire logic       O_SLEEP_PRESS,
  input wire logic [2:0] O_STATE
);
  int warn_cnt_q;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // Counts the cycles spent in the warning state.
  always_ff @(posedge I_CLK) begin
    if (O_STATE == 3'h3) warn_cnt_q <= warn_cnt_q + 1;
    else warn_cnt_q <= 0;
  end
  a_ram_off_map: assert property (O_SLEEP_RAM_OFF_N == !(O_STATE inside {3'h0, 3'h4, 3'h5}))
    else $error("rail gate wrong");
  a_soft_off_map: assert property (O_SOFT_OFF_N == !(O_STATE inside {3'h0, 3'h5}))
    else $error("soft off wrong");
  a_warn_level: assert property (O_SUSPEND_WARNING_N == (O_STATE inside {3'h1, 3'h2}))
    else $error("warning level wrong");
  a_warn_first: assert property ((O_STATE inside {3'h4, 3'h5}) && !($past(O_STATE) inside {3'h4, 3'h5})
    |-> $past(O_STATE) == 3'h3) else $error("sleep without warning");
  a_warn_span: assert property ($past(O_STATE) == 3'h3 && O_STATE != 3'h3
    |-> warn_cnt_q == pwr_seq_pkg::WARN_CYCLES) else $error("warning span wrong");
  a_power_edge: assert property ($fell(I_POWER_BUTTON_N)
    |-> ##[2:4] O_POWER_PRESS ##1 !O_POWER_PRESS) else $error("power press wrong");
  a_sleep_edge: assert property ($fell(I_SLEEP_BUTTON_N)
    |-> ##[2:4] O_SLEEP_PRESS ##1 !O_SLEEP_PRESS) else $error("sleep press wrong");
  a_battery_level: assert property ($stable(I_BATTERY_LOW_N) [*4]
    |-> O_BATTERY_LOW == !I_BATTERY_LOW_N) else $error("battery status wrong");
  a_reset_hold: assert property (!I_RESET_BUTTON_N [*4]
    |-> O_MODULE_RESET && O_STATE == 3'h0) else $error("reset button ignored");
  a_good_first: assert property ($rose(O_STATE == 3'h2)
    |-> $past(I_CARRIER_POWER_GOOD, 2)) else $error("on without power good");
  c_s3: cover property (O_STATE == 3'h4);
  c_s5: cover property (O_STATE == 3'h5);
  c_press: cover property (O_POWER_PRESS);
endmodule
bind pwr_state_ctrl pwr_state_ctrl_sva u_sva (.*);

// [carrier_model.sv]
// Carrier rails and power-good supervisor.
`timescale 1ns/1ps
module carrier_model #(
  parameter int RAMP = 20
) (
  input  wire logic i_clk,
  input  wire logic i_rail_en_n,
  output logic      o_power_good
);
  int ramp_q;
  // Rails drop at once when gated off and ramp for RAMP cycles when enabled.
  always_ff @(posedge i_clk) begin
    if (!i_rail_en_n) ramp_q <= 0;
    else if (ramp_q < RAMP) ramp_q <= ramp_q + 1;
  end
  assign o_power_good = (ramp_q == RAMP);
endmodule

// [tb_top.sv]
// Self-checking bench for the power sequencer.
`timescale 1ns/1ps
module tb_top;
  logic I_CLK, I_RESET, I_CARRIER_POWER_GOOD, I_POWER_BUTTON_N, I_RESET_BUTTON_N;
  logic I_BATTERY_LOW_N, I_WAKE_N, I_SLEEP_BUTTON_N, I_LID_SWITCH_N, I_LID_CLOSED_HIGH;
  logic [1:0] I_SLEEP_DEPTH;
  logic O_SUSPEND_WARNING_N, O_SLEEP_RAM_OFF_N, O_SOFT_OFF_N, O_MODULE_RESET, O_BATTERY_LOW;
  logic O_WAKE_EVENT, O_POWER_PRESS, O_SLEEP_PRESS, O_LID_CLOSED;
  logic [2:0] O_STATE;
  wire  [2:0] rails = {O_SUSPEND_WARNING_N, O_SLEEP_RAM_OFF_N, O_SOFT_OFF_N};
  int         mismatches;
  int         checked;
  pwr_state_ctrl i_dut (.*);
  carrier_model i_car (.i_clk(I_CLK), .i_rail_en_n(O_SLEEP_RAM_OFF_N),
                       .o_power_good(I_CARRIER_POWER_GOOD));
  initial begin
    I_CLK = 0;
    forever #20 I_CLK = ~I_CLK;
  end
  task cyc(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task chk(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({2'h0, got}, {2'h0, exp});
  endtask
  // Waits a bounded time for a state, then compares it.
  task go(input logic [2:0] s);
    int n;
    n = 0;
    while (O_STATE !== s && n < 400) begin
      cyc(1);
      n++;
    end
    chk(O_STATE, s);
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_up;
    I_POWER_BUTTON_N = 0;
    go(3'h1);
    chk1(O_POWER_PRESS, 1'b1);
    cyc(1);
    chk1(O_POWER_PRESS, 1'b0);
    I_POWER_BUTTON_N = 1;
    go(3'h2);
    chk(rails, 3'h7);
    $display("power-up ended");
  endtask
  task t_sleep;
    I_SLEEP_BUTTON_N = 0;
    go(3'h3);
    chk1(O_SLEEP_PRESS, 1'b1);
    chk(rails, 3'h3);
    I_SLEEP_BUTTON_N = 1;
    go(3'h4);
    chk(rails, 3'h1);
    I_WAKE_N = 0;
    go(3'h1);
    chk1(O_WAKE_EVENT, 1'b1);
    I_WAKE_N = 1;
    go(3'h2);
    $display("sleep and wake ended");
  endtask
  task t_lid;
    I_SLEEP_DEPTH = 2'h2;
    I_LID_SWITCH_N = 1;
    go(3'h3);
    chk1(O_LID_CLOSED, 1'b1);
    go(3'h5);
    chk(rails, 3'h0);
    I_LID_SWITCH_N = 0;
    cyc(6);
    chk(O_STATE, 3'h5);
    $display("lid ended");
  endtask
  task t_off;
    I_POWER_BUTTON_N = 0;
    go(3'h1);
    I_POWER_BUTTON_N = 1;
    go(3'h2);
    I_BATTERY_LOW_N = 0;
    cyc(4);
    chk1(O_BATTERY_LOW, 1'b1);
    I_BATTERY_LOW_N = 1;
    I_POWER_BUTTON_N = 0;
    go(3'h3);
    I_POWER_BUTTON_N = 1;
    go(3'h5);
    chk(rails, 3'h0);
    $display("power-off ended");
  endtask
  task t_rst;
    I_POWER_BUTTON_N = 0;
    go(3'h1);
    I_POWER_BUTTON_N = 1;
    go(3'h2);
    I_RESET_BUTTON_N = 0;
    cyc(4);
    chk1(O_MODULE_RESET, 1'b1);
    chk(O_STATE, 3'h0);
    I_RESET_BUTTON_N = 1;
    cyc(4);
    chk1(O_MODULE_RESET, 1'b0);
    $display("reset button ended");
  endtask
  task t_lid_low;
    I_LID_CLOSED_HIGH = 0;
    I_LID_SWITCH_N = 1;
    I_SLEEP_DEPTH = 2'h1;
    I_POWER_BUTTON_N = 0;
    go(3'h1);
    I_POWER_BUTTON_N = 1;
    go(3'h2);
    chk1(O_LID_CLOSED, 1'b0);
    I_LID_SWITCH_N = 0;
    go(3'h3);
    go(3'h4);
    chk1(O_LID_CLOSED, 1'b1);
    I_LID_SWITCH_N = 1;
    go(3'h1);
    go(3'h2);
    $display("lid low polarity ended");
  endtask
  initial begin
    mismatches = 0;
    checked = 0;
    I_RESET = 1;
    {I_POWER_BUTTON_N, I_RESET_BUTTON_N, I_BATTERY_LOW_N, I_WAKE_N, I_SLEEP_BUTTON_N} = 5'h1f;
    I_LID_SWITCH_N = 0;
    I_LID_CLOSED_HIGH = 1;
    I_SLEEP_DEPTH = 2'h1;
    cyc(8);
    I_RESET = 0;
    chk(rails, 3'h0);
    t_up;
    t_sleep;
    t_lid;
    t_off;
    t_rst;
    t_lid_low;
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
